// ===== verification/supply_model.sv
`timescale 1ns/1ps
module supply_model (
  input  wire logic clk,
  output logic      por_active,
  output logic      rst_pin_n,
  output logic      brownout_det,
  output logic      regulator_bad
);
  // ---------------------------------------------------------------
  // board reset circuit and supply monitors
  // ---------------------------------------------------------------
  // detector active from time zero; pin idles high through its pull-up
  initial
  begin
    por_active    = 1'b1;
    rst_pin_n     = 1'b1;
    brownout_det  = 1'b0;
    regulator_bad = 1'b0;
  end

  // src 0 power-on, 1 pin, 2 brown-out, 3 regulator
  task automatic set(input int src, input logic v);
    case (src)
      0: por_active = v;
      1: rst_pin_n = ~v;
      2: brownout_det = v;
      default: regulator_bad = v;
    endcase
  endtask

  // caller keeps the pin low at least the minimum pulse time
  task automatic pulse(input int src, input int n);
    @(negedge clk);
    set(src, 1'b1);
    repeat (n) @(negedge clk);
    set(src, 1'b0);
  endtask
endmodule

// ===== verification/tb.sv
`timescale 1ns/1ps
module tb;
  import rst_ctrl_pkg::*;
  localparam int unsigned NP = 8;
  logic                    clk;
  logic                    rst;
  logic                    por_active;
  logic                    rst_pin_n;
  logic                    brownout_det;
  logic                    regulator_bad;
  brownout_ctrl_s          bctl;
  logic                    reg_en;
  logic                    sw_req;
  logic [NP-1:0]           pmask;
  logic [WDT_W-1:0]        reload;
  logic [CAUSE_W-1:0]      flags;
  rst_out_s                rst_out;
  logic [NP-1:0][1:0]      periph_rst;
  logic                    brownout_irq;
  logic [31:0]             id0;
  logic [31:0]             id1;
  logic [31:0]             caps;
  logic [3:0]              seen;
  logic                    seen_irq;
  int                      error_cnt;
  int                      checks;
  int                      m_cause;
  int                      n;
  logic                    wdt_en;
  logic                    wdt_rst_en;
  logic                    wdt_clr;
  logic                    c_clear;
  logic                    wdt_irq;

  // ---------------------------------------------------------------
  // clock, far side and design
  // ---------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  supply_model sup_u (.clk(clk), .por_active(por_active),
    .rst_pin_n(rst_pin_n), .brownout_det(brownout_det),
    .regulator_bad(regulator_bad));

  // short brown-out hold keeps the run small; id values are arbitrary
  reset_source_controller #(.NPER(NP), .NDOM(2), .BOR_HOLD(40),
    .ID_WORD0(32'h0000_00a5), .ID_WORD1(32'h0000_005a),
    .CAPS_WORD(32'h0000_0c3c)) dut_u (
    .clk(clk), .rst(rst), .por_active(por_active),
    .rst_pin_n(rst_pin_n), .brownout_det(brownout_det),
    .regulator_bad(regulator_bad), .brownout_ctrl_reg(bctl),
    .regulator_reset_en(reg_en), .system_reset_request(sw_req),
    .periph_reset_regs(pmask), .wdt_enable(wdt_en),
    .wdt_reset_en(wdt_rst_en),
    .wdt_int_clear(wdt_clr), .watchdog_reload_value(reload),
    .cause_clear(c_clear), .reset_cause_flags(flags), .rst_out(rst_out),
    .periph_rst(periph_rst), .brownout_irq(brownout_irq),
    .wdt_irq(wdt_irq), .device_id_word0(id0), .device_id_word1(id1),
    .capability_regs(caps));

  // ---------------------------------------------------------------
  // checking helpers
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      $display("Error %s exp %h got %h", nm, e, g);
      error_cnt++;
    end
  endtask

  // watch a fixed window, gathering every reset domain seen active
  task automatic run(input int n);
    seen = 4'h0;
    seen_irq = 1'b0;
    repeat (n)
    begin
      @(posedge clk);
      #1;
      seen |= rst_out;
      seen_irq |= brownout_irq;
    end
  endtask

  // src 4 is the software system request; flag < 0 means no new cause
  task automatic src_test(input string nm, input int src, input int len,
                          input logic [3:0] exp_seen, input int flag);
    fork
      if (src < 4)
        sup_u.pulse(src, len);
      else
      begin
        @(negedge clk);
        sw_req = 1'b1;
        repeat (len) @(negedge clk);
        sw_req = 1'b0;
      end
      run(20);
    join
    if (flag >= 0)
      m_cause = (src == 1) ? (1 << flag) : (m_cause | (1 << flag));
    chk({nm, " seen"}, 32'(exp_seen), 32'(seen));
    chk({nm, " released"}, 32'h0, 32'(rst_out));
    chk({nm, " flags"}, 32'(m_cause), 32'(flags));
    $display("test %s done", nm);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    bctl = '0;
    reg_en = 1'b0;
    sw_req = 1'b0;
    pmask = '0;
    error_cnt = 0;
    checks = 0;
    m_cause = 0;
    wdt_en = 1'b0;
    wdt_rst_en = 1'b0;
    wdt_clr = 1'b0;
    c_clear = 1'b0;
    reload = 32'($urandom(32004) % 24 + 8);
    repeat (10) @(negedge clk);
    rst = 1'b0;
    fork
      sup_u.pulse(0, 6);
      run(16);
    join
    chk("por seen", 32'hf, 32'(seen));
    chk("por released", 32'h0, 32'(rst_out));
    chk("por flag", 32'h1, 32'(flags[CAUSE_POR]));
    src_test("pin", 1, 4, 4'hb, CAUSE_EXT);
    src_test("sw", 4, 2, 4'h9, CAUSE_SW);
    src_test("bo off", 2, 4, 4'h0, -1);
    chk("bo off irq", 32'h0, 32'(seen_irq));
    @(negedge clk);
    bctl.enable = 1'b1;
    bctl.reset_select = 1'b1;
    src_test("bo rst", 2, 4, 4'h9, CAUSE_BOR);
    src_test("bo hold", 2, 4, 4'h0, -1);
    @(negedge clk);
    bctl.reset_select = 1'b0;
    src_test("bo irq", 2, 4, 4'h0, -1);
    chk("bo irq", 32'h1, 32'(seen_irq));
    @(negedge clk);
    bctl.wait_enable = 1'b1;
    bctl.resample_delay = 16'h000a;
    src_test("bo glitch", 2, 2, 4'h0, -1);
    chk("bo glitch irq", 32'h0, 32'(seen_irq));
    src_test("bo long", 2, 20, 4'h0, -1);
    chk("bo long irq", 32'h1, 32'(seen_irq));
    src_test("ldo off", 3, 4, 4'h0, -1);
    @(negedge clk);
    reg_en = 1'b1;
    src_test("ldo", 3, 4, 4'h9, CAUSE_LDO);
    src_test("por again", 0, 4, 4'h0, -1);
    @(negedge clk);
    wdt_en = 1'b1;
    n = 0;
    while (!wdt_irq && n < 200)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("wdt irq cycles", reload + 32'h1, 32'(n));
    @(negedge clk);
    wdt_clr = 1'b1;
    @(negedge clk);
    wdt_clr = 1'b0;
    wdt_rst_en = 1'b1;
    chk("wdt clear", 32'h0, 32'(wdt_irq));
    n = 0;
    while (!wdt_irq && n < 200)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("wdt irq again", 32'h1, 32'(wdt_irq));
    run(reload + 8);
    m_cause = m_cause | (1 << CAUSE_WDT);
    chk("wdt seen", 32'h9, 32'(seen));
    chk("wdt released", 32'h0, 32'(rst_out));
    chk("wdt flags", 32'(m_cause), 32'(flags));
    @(negedge clk);
    wdt_en = 1'b0;
    wdt_rst_en = 1'b0;
    c_clear = 1'b1;
    @(negedge clk);
    c_clear = 1'b0;
    m_cause = 0;
    chk("cause clear", 32'h0, 32'(flags));
    $display("test wdt done");
    repeat (4)
    begin
      @(negedge clk);
      pmask = NP'($urandom);
      run(2);
      chk("periph core", 32'h0, 32'(seen[3]));
      for (int i = 0; i < NP; i++)
        for (int d = 0; d < 2; d++)
          chk("periph", 32'(pmask[i]), 32'(periph_rst[i][d]));
      @(negedge clk);
      pmask = '0;
      run(2);
      chk("periph off", 32'h0, 32'(periph_rst));
    end
    $display("test periph done");
    src_test("pin clear", 1, 4, 4'hb, CAUSE_EXT);
    chk("id0", 32'h0000_00a5, id0);
    chk("id1", 32'h0000_005a, id1);
    chk("caps", 32'h0000_0c3c, caps);
    $display("test id done");
    stop_test();
  end
endmodule

// ===== verilog/reset_source_controller.sv
`timescale 1ns/1ps
module reset_source_controller #(
  parameter int unsigned NPER       = rst_ctrl_pkg::NUM_PERIPH,
  parameter int unsigned NDOM       = 2,
  parameter int unsigned BOR_HOLD   = rst_ctrl_pkg::BOR_HOLD_CYC,
  parameter logic [31:0] ID_WORD0   = 32'h0000_0001,
  parameter logic [31:0] ID_WORD1   = 32'h0000_0002,
  parameter logic [31:0] CAPS_WORD  = 32'h0000_0003
) (
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire logic                              por_active,
  input  wire logic                              rst_pin_n,
  input  wire logic                              brownout_det,
  input  wire logic                              regulator_bad,
  input  wire rst_ctrl_pkg::brownout_ctrl_s      brownout_ctrl_reg,
  input  wire logic                              regulator_reset_en,
  input  wire logic                              system_reset_request,
  input  wire logic [NPER-1:0]                   periph_reset_regs,
  input  wire logic                              wdt_enable,
  input  wire logic                              wdt_reset_en,
  input  wire logic                              wdt_int_clear,
  input  wire logic [rst_ctrl_pkg::WDT_W-1:0]    watchdog_reload_value,
  input  wire logic                              cause_clear,
  output logic [rst_ctrl_pkg::CAUSE_W-1:0]       reset_cause_flags,
  output rst_ctrl_pkg::rst_out_s                 rst_out,
  output logic [NPER-1:0][NDOM-1:0]              periph_rst,
  output logic                                   brownout_irq,
  output logic                                   wdt_irq,
  output logic [31:0]                            device_id_word0,
  output logic [31:0]                            device_id_word1,
  output logic [31:0]                            capability_regs
);
  import rst_ctrl_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] por_s_q, pin_s_q, bod_s_q, reg_s_q;
  logic       por_seen_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      por_s_q <= 2'h3;
      pin_s_q <= 2'h3;
      bod_s_q <= 2'h0;
      reg_s_q <= 2'h0;
    end
    else
    begin
      por_s_q <= {por_s_q[0], por_active};
      pin_s_q <= {pin_s_q[0], rst_pin_n};
      bod_s_q <= {bod_s_q[0], brownout_det};
      reg_s_q <= {reg_s_q[0], regulator_bad};
    end
  end

  wire por_lvl  = por_s_q[1];
  wire pin_lvl  = ~pin_s_q[1];
  wire bod_lvl  = bod_s_q[1];
  wire reg_lvl  = reg_s_q[1];

  // power-on only counts before the detector first goes quiet
  always_ff @(posedge clk)
  begin
    if (rst)
      por_seen_q <= 1'b0;
    else if (!por_lvl)
      por_seen_q <= 1'b1;
  end

  wire por_src = por_lvl & ~por_seen_q;

  // ---------------------------------------------------------------
  // brown-out filter
  // ---------------------------------------------------------------
  bo_state_e        bo_q, bo_d;
  logic [TIM_W-1:0] bo_tmr_q;
  logic [31:0]      hold_q;
  logic             bo_evt;
  logic             bo_src;
  logic             bo_irq_q;

  wire bo_live   = brownout_ctrl_reg.enable & bod_lvl;
  wire bo_filt   = brownout_ctrl_reg.wait_enable &
                   ~brownout_ctrl_reg.reset_select;
  wire tmr_done  = (bo_tmr_q == brownout_ctrl_reg.resample_delay);

  always_comb
  begin
    bo_d   = bo_q;
    bo_evt = 1'b0;
    case (bo_q)
      BO_IDLE:
        if (bo_live)
        begin
          if (bo_filt)
            bo_d = BO_WAIT;
          else
            bo_evt = 1'b1;
        end
      BO_WAIT:
        if (tmr_done)
        begin
          bo_evt = bo_live;
          bo_d   = BO_IDLE;
        end
      BO_HOLD:
        if (hold_q == BOR_HOLD - 1)
          bo_d = BO_IDLE;
      default:
        bo_d = BO_IDLE;
    endcase
    if (bo_evt && brownout_ctrl_reg.reset_select)
      bo_d = BO_HOLD;
  end

  assign bo_src = bo_evt & brownout_ctrl_reg.reset_select;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bo_q     <= BO_IDLE;
      bo_tmr_q <= '0;
      hold_q   <= '0;
      bo_irq_q <= 1'b0;
    end
    else
    begin
      bo_q     <= bo_d;
      bo_tmr_q <= (bo_q == BO_WAIT) ? bo_tmr_q + 1'b1 : '0;
      hold_q   <= (bo_q == BO_HOLD) ? hold_q + 32'h1 : '0;
      bo_irq_q <= bo_evt & ~brownout_ctrl_reg.reset_select;
    end
  end

  assign brownout_irq = bo_irq_q;

  // ---------------------------------------------------------------
  // watchdog
  // ---------------------------------------------------------------
  logic [WDT_W-1:0] wdt_cnt_q;
  logic             wdt_int_q;
  logic             wdt_rst_q;

  wire wdt_zero = wdt_enable & (wdt_cnt_q == '0);

  always_ff @(posedge clk)
  begin
    if (rst || rst_out.core)
    begin
      wdt_cnt_q <= '1;
      wdt_int_q <= 1'b0;
      wdt_rst_q <= 1'b0;
    end
    else
    begin
      if (wdt_zero)
        wdt_cnt_q <= watchdog_reload_value;
      else if (wdt_enable)
        wdt_cnt_q <= wdt_cnt_q - 1'b1;
      // idle counter sits at the reload value, so enabling
      // starts a full period instead of a stale count
      else
        wdt_cnt_q <= watchdog_reload_value;
      // a new time-out beats a clear in the same cycle
      if (wdt_zero)
        wdt_int_q <= 1'b1;
      else if (wdt_int_clear)
        wdt_int_q <= 1'b0;
      wdt_rst_q <= wdt_zero & wdt_int_q & wdt_reset_en;
    end
  end

  assign wdt_irq = wdt_int_q;

  // ---------------------------------------------------------------
  // source combine and release
  // ---------------------------------------------------------------
  wire reg_src = reg_lvl & regulator_reset_en;
  wire sw_src  = system_reset_request;
  wire sys_src = bo_src | wdt_rst_q | reg_src | sw_src;
  wire any_src = por_src | pin_lvl | sys_src;

  // stretch keeps release clean after a one-cycle source
  logic [REL_STAGES-1:0] core_rel_q;
  logic [REL_STAGES-1:0] tap_rel_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      core_rel_q <= '1;
      tap_rel_q  <= '1;
    end
    else
    begin
      core_rel_q <= any_src ? '1 : {core_rel_q[REL_STAGES-2:0], 1'b0};
      tap_rel_q  <= por_src ? '1 : {tap_rel_q[REL_STAGES-2:0], 1'b0};
    end
  end

  // asserted at once from a source, dropped only after the stages; tap_pins drops with the pin
  assign rst_out.core     = any_src | core_rel_q[REL_STAGES-1];
  assign rst_out.periph   = rst_out.core;
  assign rst_out.tap      = por_src | tap_rel_q[REL_STAGES-1];
  assign rst_out.tap_pins = rst_out.tap | pin_lvl;

  // ---------------------------------------------------------------
  // per-peripheral reset, one bit per clock-gate position
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NPER; gi++)
    begin : g_per
      assign periph_rst[gi] = {NDOM{periph_reset_regs[gi] |
                                    rst_out.periph}};
    end
  endgenerate

  // ---------------------------------------------------------------
  // cause flags
  // ---------------------------------------------------------------
  logic [CAUSE_W-1:0] cause_q;
  logic [CAUSE_W-1:0] cause_set;

  always_comb
  begin
    cause_set            = '0;
    cause_set[CAUSE_EXT] = pin_lvl;
    cause_set[CAUSE_POR] = por_src;
    cause_set[CAUSE_BOR] = bo_src;
    cause_set[CAUSE_WDT] = wdt_rst_q;
    cause_set[CAUSE_SW]  = sw_src;
    cause_set[CAUSE_LDO] = reg_src;
  end

  // rst does not clear these directly; software, a pin reset or power-on does
  always_ff @(posedge clk)
  begin
    if (pin_lvl)
      cause_q <= cause_set;
    // first power-up starts from a clean set; limitation: a later
    // rst reopens the power-on window and clears them as well
    else if (por_src)
      cause_q <= CAUSE_RST_VAL | cause_set;
    else
      cause_q <= (cause_clear ? '0 : cause_q) | cause_set;
  end

  assign reset_cause_flags = cause_q;

  // identification words, values arbitrary
  assign device_id_word0 = ID_WORD0;
  assign device_id_word1 = ID_WORD1;
  assign capability_regs = CAPS_WORD;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  por_tap_a : assert property (@(posedge clk) disable iff (rst)
    por_src |-> rst_out.tap && rst_out.core)
    else $error("power-on did not reset test port");
  pin_tap_a : assert property (@(posedge clk) disable iff (rst)
    pin_lvl && !por_src && !tap_rel_q[REL_STAGES-1] |-> !rst_out.tap)
    else $error("pin reset touched test port");
  sys_tap_a : assert property (@(posedge clk) disable iff (rst)
    sys_src && !por_src && !tap_rel_q[REL_STAGES-1] |-> !rst_out.tap)
    else $error("system source reset test port");
  pin_cause_a : assert property (@(posedge clk) disable iff (rst)
    pin_lvl |=> reset_cause_flags == $past(cause_set))
    else $error("pin cause left other flags");
  wdt_reload_a : assert property (@(posedge clk) disable iff (rst)
    wdt_zero && !rst_out.core |=> wdt_cnt_q == $past(watchdog_reload_value)
      && wdt_irq)
    else $error("watchdog did not reload");
  release_a : assert property (@(posedge clk) disable iff (rst)
    any_src ##1 !any_src [*3] |-> !rst_out.core)
    else $error("core reset not released");
  bor_hold_a : assert property (@(posedge clk) disable iff (rst)
    bo_src |=> (bo_q == BO_HOLD) [*8])
    else $error("brown-out hold too short");
  bor_irq_a : assert property (@(posedge clk) disable iff (rst)
    bo_irq_q |-> !$past(brownout_ctrl_reg.reset_select))
    else $error("brown-out interrupt while reset selected");
  wdt_reset_a : assert property (@(posedge clk) disable iff (rst)
    wdt_zero && wdt_irq && wdt_reset_en && !rst_out.core |=> rst_out.core)
    else $error("watchdog second time-out gave no reset");
  periph_lo_a : assert property (@(posedge clk) disable iff (rst)
    !rst_out.periph |-> periph_rst[0] == {NDOM{periph_reset_regs[0]}})
    else $error("low peripheral reset mismatch");
  periph_hi_a : assert property (@(posedge clk) disable iff (rst)
    !rst_out.periph |-> periph_rst[NPER-1] == {NDOM{periph_reset_regs[NPER-1]}})
    else $error("high peripheral reset mismatch");
  sw_core_a : assert property (@(posedge clk) disable iff (rst)
    system_reset_request |-> rst_out.core && rst_out.periph)
    else $error("system request did not reset core");
  ldo_rst_a : assert property (@(posedge clk) disable iff (rst)
    reg_src |-> rst_out.core && rst_out.periph)
    else $error("regulator loss did not reset core");
  ldo_flag_a : assert property (@(posedge clk) disable iff (rst)
    reg_src |=> reset_cause_flags[CAUSE_LDO])
    else $error("regulator flag not set");
  cause_keep_a : assert property (@(posedge clk) disable iff (rst)
    !pin_lvl && !por_src && !cause_clear |=>
      (reset_cause_flags & $past(reset_cause_flags))
        == $past(reset_cause_flags))
    else $error("cause flag lost");
  bo_off_a : assert property (@(posedge clk) disable iff (rst)
    !brownout_ctrl_reg.enable |=> !brownout_irq)
    else $error("brown-out acted while disabled");
  bo_rst_a : assert property (@(posedge clk) disable iff (rst)
    bo_src |-> rst_out.core && rst_out.periph)
    else $error("brown-out did not reset core");
  bo_wait_a : assert property (@(posedge clk) disable iff (rst)
    bo_q == BO_WAIT && !tmr_done |-> !bo_evt)
    else $error("brown-out acted before resample");
  por_once_a : assert property (@(posedge clk) disable iff (rst)
    por_seen_q |-> !por_src)
    else $error("power-on source came back");
  por_pins_a : assert property (@(posedge clk) disable iff (rst)
    por_src |-> rst_out.tap_pins && rst_out.periph)
    else $error("power-on missed a domain");
  pin_core_a : assert property (@(posedge clk) disable iff (rst)
    pin_lvl |-> rst_out.core && rst_out.periph && rst_out.tap_pins)
    else $error("pin reset missed a domain");
endmodule

// ===== verilog/rst_ctrl_pkg.sv
package rst_ctrl_pkg;

  // ---------------------------------------------------------------
  // sizes and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ           = 10_000_000;
  localparam int unsigned BOR_HOLD_US      = 500;
  localparam int unsigned BOR_HOLD_CYC     =
    (BOR_HOLD_US * (CLK_HZ / 1_000_000));
  localparam int unsigned NUM_PERIPH       = 32;
  localparam int unsigned WDT_W            = 32;
  localparam int unsigned TIM_W            = 16;
  localparam int unsigned REL_STAGES       = 2;

  // ---------------------------------------------------------------
  // cause flag positions
  // ---------------------------------------------------------------
  localparam int unsigned CAUSE_EXT        = 0;
  localparam int unsigned CAUSE_POR        = 1;
  localparam int unsigned CAUSE_BOR        = 2;
  localparam int unsigned CAUSE_WDT        = 3;
  localparam int unsigned CAUSE_SW         = 4;
  localparam int unsigned CAUSE_LDO        = 5;
  localparam int unsigned CAUSE_W          = 6;
  localparam logic [5:0]  CAUSE_RST_VAL    = 6'h00;

  typedef enum logic [1:0]
  {
    BO_IDLE = 2'b00,
    BO_WAIT = 2'b01,
    BO_HOLD = 2'b10
  } bo_state_e;

  typedef struct packed
  {
    logic             enable;
    logic             reset_select;
    logic             wait_enable;
    logic [TIM_W-1:0] resample_delay;
  } brownout_ctrl_s;

  typedef struct packed
  {
    logic core;
    logic tap;
    logic tap_pins;
    logic periph;
  } rst_out_s;

endpackage
